// ---- tb/pps_host.sv ----
// Host model driving configuration cycles
module pps_host (
  input  wire logic        clk,
  output logic             wr,
  output logic             rd,
  output logic [7:0]       addr,
  output logic [3:0]       be,
  output logic [31:0]      wdata,
  input  wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Idle bus from time zero
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    be = 4'h0;
    wdata = 32'h0;
  end
  // Write strobe held over exactly one rising edge
  task automatic cw(input logic [7:0] a, input logic [3:0] b, input logic [15:0] d);
    @(negedge clk);
    {wr, addr, be, wdata} = {1'b1, a, b, 16'h0, d};
    @(negedge clk);
    wr = 1'b0;
  endtask : cw
  // Read data holds, so sampling a cycle late is safe
  task automatic cr(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : cr
endmodule : pps_host

// ---- tb/tb.sv ----
// Self-checking bench for the power state registers
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t %h %h", $time, a, b); end end
  logic        clk = 1'b0, rstn = 1'b0, pci_bus_reset_n = 1'b1, ev = 1'b0;
  logic        wr, rd, wake_n, cs, po, fr;
  logic [7:0]  a;
  logic [3:0]  be;
  logic [1:0]  st;
  logic [2:0]  n;
  logic [31:0] wd, rdata, d;
  int          fail_count = 0, checks_done = 0, cyc = 0;
  // Rows: byte enables, write data, expected dword
  logic [51:0] rows [5] = '{{4'h3, 16'hffff, 32'h00c00103}, {4'h1, 16'h0002, 32'h00c00102},
    {4'h1, 16'hff01, 32'h00c00101}, {4'h0, 16'hffff, 32'h00c00101}, {4'h3, 16'h7e7c, 32'h00c00000}};
  pps_top pps_top_inst (.CLK(clk), .RSTN(rstn), .PCI_RST_N(pci_bus_reset_n), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(a),
    .CFG_BE(be), .CFG_WDATA(wd), .WAKE_EVENT(ev), .CFG_RDATA(rdata), .WAKE_N(wake_n), .POWER_STATE(st),
    .SEC_CLK_STOP(cs), .SEC_POWER_OFF(po), .FUNC_RESET(fr));
  pps_host pps_host_inst (.clk(clk), .wr(wr), .rd(rd), .addr(a), .be(be), .wdata(wd), .rdata(rdata));
  // ====
  // Verdict in one place
  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  // One wake event pulse, output seen two edges on
  task automatic pulse();
    @(negedge clk);
    ev = 1'b1;
    @(negedge clk);
    ev = 1'b0;
    @(negedge clk);
  endtask : pulse
  // Bus reset held for one edge
  task automatic bus_reset();
    @(negedge clk);
    pci_bus_reset_n = 1'b0;
    @(negedge clk);
    pci_bus_reset_n = 1'b1;
  endtask : bus_reset
  // ====
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    pps_host_inst.cr(8'ha4, d);
    `CHK(d, 32'h00c00000)
    `CHK(wake_n, 1'b1)
    foreach (rows[i]) begin
      pps_host_inst.cw(8'ha4, rows[i][51:48], rows[i][47:32]);
      pps_host_inst.cr(8'ha4, d);
      `CHK(d, rows[i][31:0])
      `CHK(st, rows[i][1:0])
    end
    pps_host_inst.cw(8'ha4, 4'h3, 16'h0102);
    pulse();
    `CHK(wake_n, 1'b0)
    bus_reset();
    pps_host_inst.cr(8'ha4, d);
    `CHK(d, 32'h00c08100)
    pps_host_inst.cw(8'ha4, 4'h2, 16'h8100);
    @(negedge clk);
    `CHK(wake_n, 1'b1)
    pps_host_inst.cw(8'ha4, 4'h2, 16'h0000);
    pulse();
    `CHK(wake_n, 1'b1)
    pps_host_inst.cr(8'ha4, d);
    `CHK(d, 32'h00c08000)
    bus_reset();
    pps_host_inst.cr(8'ha4, d);
    `CHK(d, 32'h00c00000)
    pps_host_inst.cw(8'ha4, 4'h3, 16'h0103);
    @(negedge clk);
    `CHK({cs, po}, 2'h2)
    pps_host_inst.cw(8'ha4, 4'h1, 16'h0000);
    n = 3'h0;
    repeat (4) begin
      @(negedge clk);
      n = n + fr;
    end
    `CHK(n, 3'h1)
    `CHK({cs, po}, 2'h0)
    pps_host_inst.cr(8'ha4, d);
    `CHK(d, 32'h00c00100)
    pps_host_inst.cw(8'hb0, 4'hf, 16'hffff);
    pps_host_inst.cr(8'hb0, d);
    `CHK(d, 32'h00000000)
    // Global reset in mid-run clears enable, status and state alike
    pps_host_inst.cw(8'ha4, 4'h3, 16'h0103);
    pulse();
    `CHK(wake_n, 1'b0)
    rstn = 1'b0;
    @(negedge clk);
    `CHK({rdata, wake_n, st, cs, po, fr}, {32'h0, 1'b1, 5'h00})
    rstn = 1'b1;
    pps_host_inst.cr(8'ha4, d);
    `CHK(d, 32'h00c00000)
    `CHK(wake_n, 1'b1)
    complete_run();
  end
endmodule : tb

// ---- verilog/pps_pkg.sv ----
// Constants for the PCI power state control register bank
package pps_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0]  CTRL_STATUS_OFS  = 8'ha4;
  localparam logic [7:0]  BRIDGE_EXT_OFS   = 8'ha6;
  localparam logic [15:0] CTRL_STATUS_RST  = 16'h0000;
  localparam logic [7:0]  BRIDGE_EXT_VAL   = 8'hc0;
  // ==========================================================
  // Field positions
  localparam int WAKE_STATUS_BIT = 15;
  localparam int WAKE_ENABLE_BIT = 8;
  localparam int BUS_CTRL_EN_BIT = 7;
  localparam int ACTION_SEL_BIT  = 6;
  // ==========================================================
  // Power states
  typedef enum logic [1:0] {
    PPS_D0    = 2'h0,
    PPS_D1    = 2'h1,
    PPS_D2    = 2'h2,
    PPS_D3HOT = 2'h3
  } pps_state_t;
endpackage : pps_pkg

// ---- verilog/pps_reset_gen.sv ----
// One-cycle function reset pulse on a D3hot to D0 transition
module pps_reset_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] state,
  output logic            pulse
);
  logic [1:0] prev_r;

  // ==========================================================
  // Edge detect on the state field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 2'h0;
      pulse  <= 1'b0;
    end else begin
      prev_r <= state;
      pulse  <= (prev_r == pps_pkg::PPS_D3HOT) && (state == pps_pkg::PPS_D0);
    end
  end
endmodule : pps_reset_gen

// ---- verilog/pps_top.sv ----
// Power state control/status and bridge extension registers
module pps_top (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        PCI_RST_N,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  input  wire logic        WAKE_EVENT,
  output logic [31:0]      CFG_RDATA,
  output logic             WAKE_N,
  output logic [1:0]       POWER_STATE,
  output logic             SEC_CLK_STOP,
  output logic             SEC_POWER_OFF,
  output logic             FUNC_RESET
);
  logic       wake_status_r;
  logic       wake_enable_r;
  logic [1:0] state_r;
  logic       hit_dw;
  logic       wr_lo;
  logic       wr_hi;
  logic       clr_status;
  logic       func_pulse;
  logic [15:0] csr_val;
  logic       bus_power_clock_ctrl_enable;
  logic       d3hot_bus_action_select;
  logic       in_d3hot;

  // ==========================================================
  // Decode: A4h dword holds CSR (bytes 0-1) and bridge ext (byte 2)
  always_comb begin
    hit_dw = (CFG_ADDR[7:2] == pps_pkg::CTRL_STATUS_OFS[7:2]);
    wr_lo  = CFG_WR && hit_dw && CFG_BE[0];
    wr_hi  = CFG_WR && hit_dw && CFG_BE[1];
    clr_status = wr_hi && CFG_WDATA[pps_pkg::WAKE_STATUS_BIT];
  end

  // Fixed capability bits, taken from the register constant so reads and behaviour agree
  assign bus_power_clock_ctrl_enable = pps_pkg::BRIDGE_EXT_VAL[pps_pkg::BUS_CTRL_EN_BIT];
  assign d3hot_bus_action_select     = pps_pkg::BRIDGE_EXT_VAL[pps_pkg::ACTION_SEL_BIT];
  assign in_d3hot                    = (state_r == pps_pkg::PPS_D3HOT);

  // ==========================================================
  // Wake enable: a write or the global reset clears it, bus reset does not
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wake_enable_r <= 1'b0;
    end else if (wr_hi) begin
      wake_enable_r <= CFG_WDATA[pps_pkg::WAKE_ENABLE_BIT];
    end
  end

  // ==========================================================
  // Wake status: set beats clear so no event is lost
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wake_status_r <= 1'b0;
    end else if (WAKE_EVENT) begin
      wake_status_r <= 1'b1;
    end else if (!PCI_RST_N && !wake_enable_r) begin
      wake_status_r <= 1'b0;
    end else if (clr_status) begin
      wake_status_r <= 1'b0;
    end
  end

  // ==========================================================
  // Power state; function reset pulse does not touch it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= pps_pkg::PPS_D0;
    end else if (!PCI_RST_N) begin
      state_r <= pps_pkg::PPS_D0;
    end else if (wr_lo) begin
      state_r <= CFG_WDATA[1:0];
    end
  end

  pps_reset_gen pps_reset_gen_inst (
    .clk   (CLK),
    .rst_n (RSTN),
    .state (state_r),
    .pulse (func_pulse)
  );

  // ==========================================================
  // Read data, reserved and data fields read zero
  always_comb begin
    csr_val = {wake_status_r, 2'h0, 4'h0, wake_enable_r, 6'h0, state_r};
  end

  // ==========================================================
  // Read data: the A4h dword answers, any other dword reads zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CFG_RDATA <= 32'h0000_0000;
    end else if (CFG_RD && hit_dw) begin
      CFG_RDATA <= {8'h00, pps_pkg::BRIDGE_EXT_VAL, csr_val};
    end else if (CFG_RD) begin
      CFG_RDATA <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Wake output, low active; a clearing write lifts it next cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WAKE_N <= 1'b1;
    end else begin
      WAKE_N <= !(wake_status_r && wake_enable_r && !clr_status);
    end
  end

  // ==========================================================
  // State copy for the rest of the function
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      POWER_STATE <= pps_pkg::PPS_D0;
    end else begin
      POWER_STATE <= state_r;
    end
  end

  // ==========================================================
  // Secondary bus follows D3hot only while bus control is on
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SEC_CLK_STOP  <= 1'b0;
      SEC_POWER_OFF <= 1'b0;
    end else begin
      SEC_CLK_STOP  <= bus_power_clock_ctrl_enable && d3hot_bus_action_select && in_d3hot;
      SEC_POWER_OFF <= bus_power_clock_ctrl_enable && !d3hot_bus_action_select && in_d3hot;
    end
  end

  // ==========================================================
  // Function reset; the extra flop keeps this output registered too
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      FUNC_RESET <= 1'b0;
    end else begin
      FUNC_RESET <= func_pulse;
    end
  end

  // ==========================================================
  // Checks: wake status and enable
  property p_status_set;
    @(posedge CLK) disable iff (!RSTN) WAKE_EVENT |=> wake_status_r;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set");
  property p_clear;
    @(posedge CLK) disable iff (!RSTN) (clr_status && !WAKE_EVENT) |=> !wake_status_r;
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");
  property p_status_hold;
    @(posedge CLK) disable iff (!RSTN)
      (wr_hi && !CFG_WDATA[pps_pkg::WAKE_STATUS_BIT] && !WAKE_EVENT && PCI_RST_N) |=> $stable(wake_status_r);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status changed by a zero write");
  property p_en_keep;
    @(posedge CLK) disable iff (!RSTN) (!PCI_RST_N && !wr_hi) |=> $stable(wake_enable_r);
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("enable lost on bus reset");
  // Bus reset clears the wake context only while wake is disabled
  property p_bus_clear;
    @(posedge CLK) disable iff (!RSTN) (!PCI_RST_N && !wake_enable_r && !WAKE_EVENT) |=> !wake_status_r;
  endproperty
  a_bus_clear: assert property (p_bus_clear) else $error("context kept on bus reset while disabled");
  property p_ctx_keep;
    @(posedge CLK) disable iff (!RSTN)
      (!PCI_RST_N && wake_enable_r && !clr_status && !WAKE_EVENT) |=> $stable(wake_status_r);
  endproperty
  a_ctx_keep: assert property (p_ctx_keep) else $error("context lost on bus reset while enabled");
  // Wake output gating
  property p_gate;
    @(posedge CLK) disable iff (!RSTN) !wake_enable_r |=> WAKE_N;
  endproperty
  a_gate: assert property (p_gate) else $error("wake asserted while disabled");
  property p_wake;
    @(posedge CLK) disable iff (!RSTN) (wake_status_r && wake_enable_r && !clr_status) |=> !WAKE_N;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not asserted");
  // Read data layout
  property p_reserved_zero;
    @(posedge CLK) disable iff (!RSTN) (CFG_RD && hit_dw) |=> (CFG_RDATA[14:9] == 6'h0 && CFG_RDATA[7:2] == 6'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");
  property p_ext;
    @(posedge CLK) disable iff (!RSTN) (CFG_RD && hit_dw) |=> CFG_RDATA[23:16] == 8'hc0;
  endproperty
  a_ext: assert property (p_ext) else $error("bridge ext wrong");
  property p_state_read;
    @(posedge CLK) disable iff (!RSTN) (CFG_RD && hit_dw) |=> CFG_RDATA[1:0] == $past(state_r);
  endproperty
  a_state_read: assert property (p_state_read) else $error("state field reads wrong");
  // Power state and secondary bus
  property p_state;
    @(posedge CLK) disable iff (!RSTN) (wr_lo && PCI_RST_N) |=> ##1 POWER_STATE == $past(CFG_WDATA[1:0], 2);
  endproperty
  a_state: assert property (p_state) else $error("state not written");
  property p_clkstop;
    @(posedge CLK) disable iff (!RSTN) in_d3hot |=> SEC_CLK_STOP && !SEC_POWER_OFF;
  endproperty
  a_clkstop: assert property (p_clkstop) else $error("no clock stop in D3hot");
  property p_sec_release;
    @(posedge CLK) disable iff (!RSTN) !in_d3hot |=> !SEC_CLK_STOP && !SEC_POWER_OFF;
  endproperty
  a_sec_release: assert property (p_sec_release) else $error("secondary bus held outside D3hot");
  // Function reset, and the register it must leave alone
  property p_func_reset;
    @(posedge CLK) disable iff (!RSTN)
      in_d3hot ##1 (state_r == pps_pkg::PPS_D0) |-> ##2 FUNC_RESET;
  endproperty
  a_func_reset: assert property (p_func_reset) else $error("no function reset on leaving D3hot");
  property p_func_keep;
    @(posedge CLK) disable iff (!RSTN)
      (func_pulse && PCI_RST_N && !CFG_WR && !WAKE_EVENT) |=> $stable(csr_val);
  endproperty
  a_func_keep: assert property (p_func_keep) else $error("register altered by function reset");
  // Main scenarios
  c_wake: cover property (@(posedge CLK) disable iff (!RSTN) !WAKE_N);
  c_d3: cover property (@(posedge CLK) disable iff (!RSTN) SEC_CLK_STOP);
  c_func: cover property (@(posedge CLK) disable iff (!RSTN) FUNC_RESET);
  c_ctx_kept: cover property (@(posedge CLK) disable iff (!RSTN) !PCI_RST_N && wake_status_r && wake_enable_r);
endmodule : pps_top
